// *** src/fpec_ctrl.sv ***
// Purpose: Control, status and pulse timing of the data flash program and erase interface.
// Assumes: The flash array and its CPU write port run on clk; array fail flags are valid when sampled.
// Notes: One command is buffered while another runs; the array sees one command at a time.
`timescale 1ns/1ns
`default_nettype none

module fpec_ctrl (
  input wire logic clk,
  input wire logic srst,
  // CPU peripheral bus register port.
  input wire logic [23:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata_q,
  output logic reg_rvalid_q,
  // CPU accesses aimed at the data flash array.
  input wire logic flash_wr,
  input wire logic flash_rd,
  input wire logic flash_info,
  input wire logic [fpec_pkg::FLASH_ADDR_W-1:0] flash_addr,
  input wire logic [15:0] flash_wdata,
  output logic cpu_stall_q,
  // Pulse width settings from the timing reload registers.
  input wire logic [7:0] program_pulse_count,
  input wire logic [7:0] page_erase_pulse_count,
  input wire logic [7:0] module_erase_pulse_count,
  // Flash array side.
  output fpec_pkg::fpec_cmd_t arr_cmd_q,
  output logic arr_pulse_q,
  output logic arr_verify_q,
  output logic arr_low_power_read_q,
  input wire logic arr_erase_fail,
  input wire logic arr_verify_fail,
  // Interrupt request to the shared flash channel.
  output logic irq_q
);

  typedef enum logic [1:0] {
    FPEC_ST_IDLE,
    FPEC_ST_PULSE,
    FPEC_ST_VERIFY,
    FPEC_ST_CHECK
  } fpec_state_t;

  logic [15:0] section_we_q;
  logic [7:0] control_q;
  logic [4:0] divisor_q;
  logic erase_error_q;
  logic program_error_q;
  logic busy_q;
  logic buffer_full_q;
  logic data_loss_q;
  fpec_pkg::fpec_cmd_t buffer_q;
  fpec_state_t state_q;
  logic [4:0] prescale_cnt_q;
  logic [fpec_pkg::PULSE_CNT_W-1:0] tick_cnt_q;
  logic [fpec_pkg::PULSE_CNT_W-1:0] pulse_len_q;

  logic wr_section_we;
  logic wr_control;
  logic wr_status;
  logic wr_prescaler;
  logic tick;
  logic start_op;
  logic pulse_last;
  logic req_valid;
  logic req_accept;
  logic req_overrun;
  fpec_pkg::fpec_op_t req_op;
  logic [7:0] status_view;

  // Pulse length in prescaler output clocks for a given operation.
  function automatic logic [fpec_pkg::PULSE_CNT_W-1:0] pulse_ticks(
    input fpec_pkg::fpec_op_t op,
    input logic [7:0] prog_cnt,
    input logic [7:0] page_cnt,
    input logic [7:0] mod_cnt
  );
    logic [fpec_pkg::PULSE_CNT_W-1:0] base;
    base = '0;
    case (op)
      fpec_pkg::FPEC_OP_PROGRAM: begin
        base = fpec_pkg::PULSE_CNT_W'({13'h0000, prog_cnt} + 21'h000001);
        pulse_ticks = fpec_pkg::PULSE_CNT_W'(base * fpec_pkg::PROGRAM_PULSE_SCALE);
      end
      fpec_pkg::FPEC_OP_PAGE_ERASE: begin
        base = fpec_pkg::PULSE_CNT_W'({13'h0000, page_cnt} + 21'h000001);
        pulse_ticks = fpec_pkg::PULSE_CNT_W'(base * fpec_pkg::ERASE_PULSE_SCALE);
      end
      default: begin
        base = fpec_pkg::PULSE_CNT_W'({13'h0000, mod_cnt} + 21'h000001);
        pulse_ticks = fpec_pkg::PULSE_CNT_W'(base * fpec_pkg::ERASE_PULSE_SCALE);
      end
    endcase
  endfunction : pulse_ticks

  // Register address decode.
  always_comb begin
    wr_section_we = 1'b0;
    wr_control = 1'b0;
    wr_status = 1'b0;
    wr_prescaler = 1'b0;
    if (reg_addr == fpec_pkg::ADDR_SECTION_WE) begin
      wr_section_we = reg_wr;
    end else if (reg_addr == fpec_pkg::ADDR_CONTROL) begin
      wr_control = reg_wr;
    end else if (reg_addr == fpec_pkg::ADDR_STATUS) begin
      wr_status = reg_wr;
    end else if (reg_addr == fpec_pkg::ADDR_PRESCALER) begin
      wr_prescaler = reg_wr;
    end
  end

  // Only one mode is meant to be set; the order below keeps a wrong mix deterministic.
  always_comb begin
    req_op = fpec_pkg::FPEC_OP_PROGRAM;
    req_valid = 1'b0;
    if (flash_wr && !control_q[fpec_pkg::CTL_CPU_WRITE_DISABLE]) begin
      if (control_q[fpec_pkg::CTL_MODULE_ERASE_ENABLE]) begin
        req_op = fpec_pkg::FPEC_OP_MODULE_ERASE;
        req_valid = flash_info || section_we_q[flash_addr[fpec_pkg::FLASH_ADDR_W-1:fpec_pkg::SECTION_LSB]];
      end else if (control_q[fpec_pkg::CTL_PAGE_ERASE_ENABLE]) begin
        req_op = fpec_pkg::FPEC_OP_PAGE_ERASE;
        req_valid = !flash_info && section_we_q[flash_addr[fpec_pkg::FLASH_ADDR_W-1:fpec_pkg::SECTION_LSB]];
      end else if (control_q[fpec_pkg::CTL_PROGRAM_ENABLE]) begin
        req_op = fpec_pkg::FPEC_OP_PROGRAM;
        req_valid = flash_info || section_we_q[flash_addr[fpec_pkg::FLASH_ADDR_W-1:fpec_pkg::SECTION_LSB]];
      end
    end
  end

  assign req_accept = req_valid && !buffer_full_q;
  assign req_overrun = req_valid && buffer_full_q;
  assign start_op = (state_q == FPEC_ST_IDLE) && buffer_full_q;
  assign tick = (prescale_cnt_q == divisor_q);
  assign pulse_last = (state_q == FPEC_ST_PULSE) && tick && (tick_cnt_q == pulse_len_q - 21'h000001);

  // Section write enables.
  always_ff @(posedge clk) begin
    if (srst) begin
      section_we_q <= fpec_pkg::SECTION_WE_RST;
    end else if (wr_section_we) begin
      section_we_q <= reg_wdata;
    end
  end

  // Control register; the reserved bit stays zero.
  always_ff @(posedge clk) begin
    if (srst) begin
      control_q <= fpec_pkg::CONTROL_RST;
    end else if (wr_control) begin
      control_q <= reg_wdata[7:0] & fpec_pkg::CONTROL_WRITE_MASK;
    end
  end

  // Prescaler divisor.
  always_ff @(posedge clk) begin
    if (srst) begin
      divisor_q <= fpec_pkg::PRESCALER_RST;
    end else if (wr_prescaler) begin
      divisor_q <= reg_wdata[4:0];
    end
  end

  // Prescaler restarts with each operation so the first pulse clock is a full one.
  always_ff @(posedge clk) begin
    if (srst || start_op || tick) begin
      prescale_cnt_q <= 5'h00;
    end else begin
      prescale_cnt_q <= prescale_cnt_q + 5'h01;
    end
  end

  // Write buffer of one command.
  always_ff @(posedge clk) begin
    if (srst) begin
      buffer_full_q <= 1'b0;
      buffer_q <= '0;
    end else begin
      if (req_accept) begin
        buffer_full_q <= 1'b1;
        buffer_q.op <= req_op;
        buffer_q.info_block <= flash_info;
        buffer_q.addr <= flash_addr;
        buffer_q.data <= flash_wdata;
      end else if (start_op) begin
        buffer_full_q <= 1'b0;
      end
    end
  end

  // Operation sequencer.
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= FPEC_ST_IDLE;
      busy_q <= 1'b0;
      arr_cmd_q <= '0;
      arr_pulse_q <= 1'b0;
      arr_verify_q <= 1'b0;
      tick_cnt_q <= '0;
      pulse_len_q <= '0;
    end else begin
      arr_verify_q <= 1'b0;
      case (state_q)
        FPEC_ST_IDLE: begin
          if (start_op) begin
            busy_q <= 1'b1;
            arr_cmd_q <= buffer_q;
            arr_pulse_q <= 1'b1;
            tick_cnt_q <= '0;
            pulse_len_q <= pulse_ticks(buffer_q.op, program_pulse_count, page_erase_pulse_count,
                                       module_erase_pulse_count);
            state_q <= FPEC_ST_PULSE;
          end
        end
        FPEC_ST_PULSE: begin
          if (pulse_last) begin
            arr_pulse_q <= 1'b0;
            if (arr_cmd_q.op == fpec_pkg::FPEC_OP_PROGRAM && !control_q[fpec_pkg::CTL_VERIFY_DISABLE]) begin
              state_q <= FPEC_ST_VERIFY;
            end else begin
              busy_q <= 1'b0;
              state_q <= FPEC_ST_IDLE;
            end
          end else if (tick) begin
            tick_cnt_q <= tick_cnt_q + 21'h000001;
          end
        end
        FPEC_ST_VERIFY: begin
          arr_verify_q <= 1'b1;
          state_q <= FPEC_ST_CHECK;
        end
        default: begin
          busy_q <= 1'b0;
          state_q <= FPEC_ST_IDLE;
        end
      endcase
    end
  end

  // Error flags; a hardware set in the same cycle as a software clear wins.
  always_ff @(posedge clk) begin
    if (srst) begin
      erase_error_q <= 1'b0;
    end else if (pulse_last && arr_cmd_q.op != fpec_pkg::FPEC_OP_PROGRAM && arr_erase_fail) begin
      erase_error_q <= 1'b1;
    end else if (wr_status && reg_wdata[fpec_pkg::STS_ERASE_ERROR]) begin
      erase_error_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      program_error_q <= 1'b0;
    end else if (state_q == FPEC_ST_CHECK && arr_verify_fail) begin
      program_error_q <= 1'b1;
    end else if (wr_status && reg_wdata[fpec_pkg::STS_PROGRAM_ERROR]) begin
      program_error_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      data_loss_q <= 1'b0;
    end else if (req_overrun) begin
      data_loss_q <= 1'b1;
    end else if (wr_status && reg_wdata[fpec_pkg::STS_DATA_LOSS_ERROR]) begin
      data_loss_q <= 1'b0;
    end
  end

  // Interrupt pulse as the buffer empties into the array.
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= start_op && control_q[fpec_pkg::CTL_PROGRAM_IRQ_ENABLE];
    end
  end

  // Reads of the array while busy hold the CPU until the operation ends.
  always_ff @(posedge clk) begin
    if (srst) begin
      cpu_stall_q <= 1'b0;
    end else begin
      cpu_stall_q <= flash_rd && (busy_q || start_op);
    end
  end

  // Phase control for low-power reads is done by the array on this level.
  always_ff @(posedge clk) begin
    if (srst) begin
      arr_low_power_read_q <= 1'b0;
    end else begin
      arr_low_power_read_q <= control_q[fpec_pkg::CTL_LOW_POWER_READ];
    end
  end

  always_comb begin
    status_view = fpec_pkg::STATUS_RST;
    status_view[fpec_pkg::STS_ERASE_ERROR] = erase_error_q;
    status_view[fpec_pkg::STS_PROGRAM_ERROR] = program_error_q;
    status_view[fpec_pkg::STS_FLASH_BUSY] = busy_q;
    status_view[fpec_pkg::STS_BUFFER_FULL] = buffer_full_q;
    status_view[fpec_pkg::STS_DATA_LOSS_ERROR] = data_loss_q;
  end

  // Read data is registered; unmapped addresses read zero.
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata_q <= 16'h0000;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
      if (!reg_rd) begin
        reg_rdata_q <= 16'h0000;
      end else if (reg_addr == fpec_pkg::ADDR_SECTION_WE) begin
        reg_rdata_q <= section_we_q;
      end else if (reg_addr == fpec_pkg::ADDR_CONTROL) begin
        reg_rdata_q <= {8'h00, control_q};
      end else if (reg_addr == fpec_pkg::ADDR_STATUS) begin
        reg_rdata_q <= {8'h00, status_view};
      end else if (reg_addr == fpec_pkg::ADDR_PRESCALER) begin
        reg_rdata_q <= {11'h000, divisor_q};
      end else begin
        reg_rdata_q <= 16'h0000;
      end
    end
  end

endmodule : fpec_ctrl

`default_nettype wire

// *** src/fpec_pkg.sv ***
// Purpose: Shared constants and types of the data flash program and erase controller.
// Assumes: One system clock; the CPU peripheral bus carries 24-bit addresses and 16-bit data.
// Notes: Byte-wide registers sit in the low byte of the data word and read zero above it.
package fpec_pkg;

  // Register addresses on the CPU peripheral bus.
  localparam logic [23:0] ADDR_SECTION_WE = 24'hFFF744;
  localparam logic [23:0] ADDR_CONTROL = 24'hFFF74C;
  localparam logic [23:0] ADDR_STATUS = 24'hFFF74E;
  localparam logic [23:0] ADDR_PRESCALER = 24'hFFF750;

  // Values after reset.
  localparam logic [15:0] SECTION_WE_RST = 16'h0000;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [4:0] PRESCALER_RST = 5'h04;

  // Control register bit positions.
  localparam int CTL_LOW_POWER_READ = 0;
  localparam int CTL_CPU_WRITE_DISABLE = 1;
  localparam int CTL_VERIFY_DISABLE = 3;
  localparam int CTL_PROGRAM_IRQ_ENABLE = 4;
  localparam int CTL_PROGRAM_ENABLE = 5;
  localparam int CTL_PAGE_ERASE_ENABLE = 6;
  localparam int CTL_MODULE_ERASE_ENABLE = 7;
  localparam logic [7:0] CONTROL_WRITE_MASK = 8'hFB;

  // Status register bit positions.
  localparam int STS_ERASE_ERROR = 0;
  localparam int STS_PROGRAM_ERROR = 1;
  localparam int STS_FLASH_BUSY = 2;
  localparam int STS_BUFFER_FULL = 3;
  localparam int STS_DATA_LOSS_ERROR = 4;

  // Data flash geometry: 16 sections of 512 bytes, pages of 1024 bytes.
  localparam int FLASH_ADDR_W = 13;
  localparam int SECTION_LSB = 9;
  localparam int PAGE_LSB = 10;

  // Pulse length scaling in prescaler output clocks.
  localparam int PULSE_CNT_W = 21;
  localparam logic [PULSE_CNT_W-1:0] PROGRAM_PULSE_SCALE = 21'h000008;
  localparam logic [PULSE_CNT_W-1:0] ERASE_PULSE_SCALE = 21'h001000;

  typedef enum logic [1:0] {
    FPEC_OP_PROGRAM,
    FPEC_OP_PAGE_ERASE,
    FPEC_OP_MODULE_ERASE
  } fpec_op_t;

  typedef struct packed {
    fpec_op_t op;
    logic info_block;
    logic [FLASH_ADDR_W-1:0] addr;
    logic [15:0] data;
  } fpec_cmd_t;

endpackage : fpec_pkg

// *** sim/fpec_ctrl_sva.sv ***
// Purpose: Port assertions for the data flash program and erase controller.
// Assumes: Pulse counts and the prescaler divisor stay steady while a pulse runs.
// Notes: Shadow copies of control and section enables follow bus writes.
`timescale 1ns/1ns
`default_nettype none
module fpec_ctrl_sva (
  input wire logic clk,
  input wire logic srst,
  input wire logic [23:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata_q,
  input wire logic reg_rvalid_q,
  input wire logic flash_wr,
  input wire logic flash_info,
  input wire logic [fpec_pkg::FLASH_ADDR_W-1:0] flash_addr,
  input wire logic [7:0] program_pulse_count,
  input wire fpec_pkg::fpec_cmd_t arr_cmd_q,
  input wire logic arr_pulse_q,
  input wire logic arr_verify_q,
  input wire logic irq_q
);
  logic [7:0] ctl_q;
  logic [15:0] sec_q;
  logic [4:0] div_q;
  logic [11:0] hi_q;
  logic ok_wr;
  logic idle;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  always_ff @(posedge clk) begin
    if (srst) begin
      ctl_q <= 8'h00;
      sec_q <= 16'h0000;
      div_q <= fpec_pkg::PRESCALER_RST;
    end else if (reg_wr) begin
      if (reg_addr == fpec_pkg::ADDR_CONTROL) ctl_q <= reg_wdata[7:0] & fpec_pkg::CONTROL_WRITE_MASK;
      if (reg_addr == fpec_pkg::ADDR_SECTION_WE) sec_q <= reg_wdata;
      if (reg_addr == fpec_pkg::ADDR_PRESCALER) div_q <= reg_wdata[4:0];
    end
  end
  // Wraps on erase pulses, which is harmless since only program pulses are measured.
  always_ff @(posedge clk) begin
    if (srst || !arr_pulse_q) hi_q <= 12'h000;
    else hi_q <= hi_q + 12'h001;
  end
  assign ok_wr = flash_wr && !ctl_q[1] && (ctl_q[7] || (ctl_q[6] ? !flash_info : ctl_q[5]))
    && (flash_info || sec_q[flash_addr[12:9]]);
  assign idle = !arr_pulse_q && !arr_verify_q;
  reset_out_a: assert property ($fell(srst) |-> !arr_pulse_q && !irq_q && !reg_rvalid_q)
    else $error("output active after reset");
  cwd_block_a: assert property (flash_wr && ctl_q[1] && idle && !$past(flash_wr) |-> ##2 !arr_pulse_q)
    else $error("write disable ignored");
  sect_block_a: assert property (flash_wr && !flash_info && !sec_q[flash_addr[12:9]] && idle && !$past(flash_wr)
    |-> ##2 !arr_pulse_q) else $error("protected section written");
  pulse_start_a: assert property (ok_wr && idle && !$past(flash_wr) |-> ##1 !arr_pulse_q ##1 arr_pulse_q)
    else $error("valid write did not start");
  irq_when_a: assert property (irq_q |-> ctl_q[4] && $rose(arr_pulse_q))
    else $error("stray interrupt");
  prog_len_a: assert property ($fell(arr_pulse_q) && arr_cmd_q.op == fpec_pkg::FPEC_OP_PROGRAM
    |-> hi_q == 8 * (program_pulse_count + 1) * (div_q + 1)) else $error("program pulse length");
  verify_on_a: assert property ($fell(arr_pulse_q) && arr_cmd_q.op == fpec_pkg::FPEC_OP_PROGRAM && !ctl_q[3]
    |-> ##[0:1] arr_verify_q) else $error("verify missing");
  ctl_read_a: assert property (reg_rd && reg_addr == fpec_pkg::ADDR_CONTROL |=> reg_rdata_q == {8'h00, ctl_q})
    else $error("control readback");
endmodule : fpec_ctrl_sva
bind fpec_ctrl fpec_ctrl_sva u_sva (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
  .flash_wr(flash_wr), .flash_info(flash_info), .flash_addr(flash_addr),
  .program_pulse_count(program_pulse_count), .arr_cmd_q(arr_cmd_q), .arr_pulse_q(arr_pulse_q),
  .arr_verify_q(arr_verify_q), .irq_q(irq_q));
`default_nettype wire

// *** sim/fpec_array_model.sv ***
// Purpose: Flash array stand-in answering the erase and verify fail lines.
// Assumes: The bench decides when an operation fails.
// Notes: Fail lines carry a moving pattern while their request line (arr_pulse_q or arr_verify_q) is low.
`timescale 1ns/1ns
`default_nettype none
module fpec_array_model (
  input wire logic clk,
  input wire logic arr_pulse_q,
  input wire logic arr_verify_q,
  input wire logic want_erase_fail,
  input wire logic want_verify_fail,
  output logic arr_erase_fail,
  output logic arr_verify_fail
);
  logic flip_q;
  always_ff @(posedge clk) begin
    flip_q <= (flip_q !== 1'b1);
  end
  // A design that samples late picks up the pattern, not the answer.
  assign arr_erase_fail = arr_pulse_q ? want_erase_fail : flip_q;
  // The verify answer stands with the verify request, the cycle the controller checks it.
  assign arr_verify_fail = arr_verify_q ? want_verify_fail : flip_q;
endmodule : fpec_array_model
`default_nettype wire

// *** sim/tb_flash_program_erase_ctrl.sv ***
// Purpose: Self-checking bench for the data flash program and erase controller.
// Assumes: Divisor zero and small pulse counts keep the run short.
// Notes: Reads queue their expected data; a monitor compares each answer.
`timescale 1ns/1ns
`default_nettype none
module tb_flash_program_erase_ctrl;
  localparam logic [23:0] STS = fpec_pkg::ADDR_STATUS;
  localparam logic [23:0] CTL = fpec_pkg::ADDR_CONTROL;
  localparam logic [23:0] SWE = fpec_pkg::ADDR_SECTION_WE;
  localparam logic [1:0] PR = fpec_pkg::FPEC_OP_PROGRAM;
  logic clk;
  logic srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, flash_wr = 1'b0, flash_rd = 1'b0, flash_info = 1'b0;
  logic want_e = 1'b0, want_v = 1'b0;
  logic reg_rvalid_q, cpu_stall_q, arr_pulse_q, arr_verify_q, arr_low_power_read_q, arr_erase_fail;
  logic arr_verify_fail, irq_q;
  logic [23:0] reg_addr = 24'h000000;
  logic [15:0] reg_wdata = 16'h0000, flash_wdata = 16'h0000, reg_rdata_q, r;
  logic [12:0] flash_addr = 13'h0000;
  logic [7:0] program_pulse_count = 8'h00, page_erase_pulse_count = 8'h00, module_erase_pulse_count = 8'h00;
  fpec_pkg::fpec_cmd_t arr_cmd_q;
  logic [15:0] exp_q[$];
  int seed = 32'hFC4A;
  int n_mismatch = 0, num_checks = 0, irq_n = 0, cyc = 0;
  fpec_ctrl DUT (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q), .flash_wr(flash_wr),
    .flash_rd(flash_rd), .flash_info(flash_info), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .cpu_stall_q(cpu_stall_q), .program_pulse_count(program_pulse_count),
    .page_erase_pulse_count(page_erase_pulse_count), .module_erase_pulse_count(module_erase_pulse_count),
    .arr_cmd_q(arr_cmd_q), .arr_pulse_q(arr_pulse_q), .arr_verify_q(arr_verify_q),
    .arr_low_power_read_q(arr_low_power_read_q), .arr_erase_fail(arr_erase_fail),
    .arr_verify_fail(arr_verify_fail), .irq_q(irq_q));
  fpec_array_model u_array (.clk(clk), .arr_pulse_q(arr_pulse_q), .arr_verify_q(arr_verify_q),
    .want_erase_fail(want_e), .want_verify_fail(want_v), .arr_erase_fail(arr_erase_fail),
    .arr_verify_fail(arr_verify_fail));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [23:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rd
  // Holding the write strobe for n edges makes n back-to-back requests.
  task automatic fw(input logic i, input logic [12:0] a, input int n, input logic run, input logic [1:0] op);
    int w;
    @(posedge clk);
    flash_info <= i;
    flash_addr <= a;
    flash_wdata <= 16'($random(seed));
    flash_wr <= 1'b1;
    repeat (n) @(posedge clk);
    flash_wr <= 1'b0;
    w = 0;
    while (arr_pulse_q !== 1'b1 && w < 6) begin
      @(posedge clk);
      w++;
    end
    chk("pulse", {15'h0000, arr_pulse_q}, {15'h0000, run});
    if (run) begin
      chk("op", {14'h0000, arr_cmd_q.op}, {14'h0000, op});
      chk("addr", {3'h0, arr_cmd_q.addr}, {3'h0, a});
      chk("info", {15'h0000, arr_cmd_q.info_block}, {15'h0000, i});
      chk("data", arr_cmd_q.data, flash_wdata);
      flash_rd <= 1'b1;
      repeat (2) @(posedge clk);
      chk("stall", {15'h0000, cpu_stall_q}, 16'h0001);
      flash_rd <= 1'b0;
    end
    while (arr_pulse_q === 1'b1) @(posedge clk);
    // Busy has cleared before any mode bit or error flag is touched again.
    repeat (5) @(posedge clk);
  endtask : fw
  always @(posedge clk) begin
    cyc++;
    if (reg_rvalid_q === 1'b1 && exp_q.size() > 0) chk("rdata", reg_rdata_q, exp_q.pop_front());
    if (irq_q === 1'b1) irq_n++;
    if (cyc == 30000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rd(SWE, 16'h0000);
    rd(CTL, 16'h0000);
    rd(STS, 16'h0000);
    rd(fpec_pkg::ADDR_PRESCALER, 16'h0004);
    rd(24'hFFF746, 16'h0000);
    r = 16'($random(seed));
    wr(SWE, r);
    rd(SWE, r);
    wr(CTL, 16'h00FF);
    rd(CTL, 16'h00FB);
    wr(CTL, 16'h0001);
    repeat (2) @(posedge clk);
    chk("low_power", {15'h0000, arr_low_power_read_q}, 16'h0001);
    wr(fpec_pkg::ADDR_PRESCALER, 16'h0000);
    wr(SWE, 16'h8001);
    program_pulse_count <= 8'($random(seed)) & 8'h03;
    wr(CTL, 16'h0022);
    fw(1'b0, 13'h0000, 1, 1'b0, PR);
    wr(CTL, 16'h0030);
    fw(1'b0, 13'h0200, 1, 1'b0, PR);
    fw(1'b0, 13'h1FFE, 1, 1'b1, PR);
    want_v <= 1'b1;
    fw(1'b0, 13'h01FE, 1, 1'b1, PR);
    rd(STS, 16'h0002);
    wr(STS, 16'h0000);
    rd(STS, 16'h0002);
    wr(STS, 16'h0002);
    wr(CTL, 16'h0028);
    fw(1'b0, 13'h0002, 1, 1'b1, PR);
    rd(STS, 16'h0000);
    want_v <= 1'b0;
    fw(1'b0, 13'h0004, 2, 1'b1, PR);
    rd(STS, 16'h0010);
    wr(STS, 16'h0010);
    rd(STS, 16'h0000);
    wr(fpec_pkg::ADDR_PRESCALER, 16'h0001);
    fw(1'b0, 13'h0006, 1, 1'b1, PR);
    wr(fpec_pkg::ADDR_PRESCALER, 16'h0000);
    wr(CTL, 16'h0040);
    want_e <= 1'b1;
    fw(1'b0, 13'h1E00, 1, 1'b1, fpec_pkg::FPEC_OP_PAGE_ERASE);
    rd(STS, 16'h0001);
    wr(STS, 16'h0001);
    want_e <= 1'b0;
    fw(1'b1, 13'h0000, 1, 1'b0, fpec_pkg::FPEC_OP_PAGE_ERASE);
    wr(CTL, 16'h0080);
    fw(1'b1, 13'h0000, 1, 1'b1, fpec_pkg::FPEC_OP_MODULE_ERASE);
    rd(STS, 16'h0000);
    repeat (3) @(posedge clk);
    chk("irq_count", irq_n[15:0], 16'h0002);
    report_and_stop();
  end
endmodule : tb_flash_program_erase_ctrl
`default_nettype wire
